// File: design/dcif_top.v
// dma channel interrupt flags with apb register access
// ==========================================
// Summary of operation
// - complete flag of channel n at bit n
// - bit 7 reads zero, writes ignored
// - complete set when offset equals size minus one
// - flags sticky until software clear or reset
// - config bit 7 enables complete interrupt
// - midpoint flag of channel n at bit n
// - midpoint at half size, odd adds one
// - config bit 6 enables midpoint interrupt
// - midpoint register at page 2, 0xd4; the code decodes paddr_i 0x0d4 only and never uses DCIF_MIDPOINT_PAGE
// - set flag holds off next channel transfer, except on a channel with wrap set
// - select 0..6 routes config, 7 invalid
// - wrap resets offset to zero at end
`timescale 1ns/10ps
`include "dcif_consts.vh"
module dcif_top
#(
   parameter NCH = 7,
   parameter OW  = 10
)
(
   // clock and reset
   input  wire              clock_i,
   input  wire              rst_i,
   // apb slave
   input  wire              psel_i,
   input  wire              penable_i,
   input  wire              pwrite_i,
   input  wire [11:0]       paddr_i,
   input  wire [31:0]       pwdata_i,
   input  wire [3:0]        pstrb_i,
   output reg  [31:0]       prdata_o,
   output reg               pready_o,
   output reg               pslverr_o,
   // channel counters, flat, channel n at [n*OW +: OW]
   input  wire [NCH*OW-1:0] offset_i,
   input  wire [NCH*OW-1:0] size_i,
   input  wire [NCH-1:0]    byte_done_i,
   // engine controls
   output reg  [NCH-1:0]    offset_clear_o,
   output reg  [NCH-1:0]    hold_o,
   output reg  [NCH-1:0]    wrap_o,
   // interrupts
   output reg               dma_irq_o,
   output reg               block_irq_o
);
   // ==========================================
   // declarations
   reg  [NCH-1:0] complete_reg;
   reg  [NCH-1:0] complete_next;
   reg  [NCH-1:0] midpoint_reg;
   reg  [NCH-1:0] midpoint_next;
   reg  [2:0]     select_reg;
   reg  [NCH-1:0] wrap_reg;
   reg  [1:0]     status_reg;
   reg  [1:0]     status_next;
   reg  [1:0]     mask_reg;
   reg  [NCH-1:0] end_d_reg;
   reg  [NCH-1:0] mid_d_reg;
   reg            rd_cfg_reg;
   wire [NCH-1:0] at_end_w;
   wire [NCH-1:0] at_mid_w;
   wire [NCH-1:0] end_rise_w;
   wire [NCH-1:0] mid_rise_w;
   wire [NCH-1:0] complete_en_w;
   wire [NCH-1:0] midpoint_en_w;
   wire [7:0]     cfg_rd_w;
   wire           access_w;
   wire           wr_w;
   wire           rd_w;
   wire           sel_valid_w;
   wire           cfg_wr_w;
   reg  [31:0]    rdata_w;
   reg            hit_w;
   genvar         g;

   // ==========================================
   // bus decode
   function [31:0] byte0;
      input [7:0] v;
      begin
         byte0 = {24'h00_0000, v};
      end
   endfunction

   function [7:0] pad_flags;
      input [NCH-1:0] v;
      begin
         pad_flags = 8'h00;
         pad_flags[NCH-1:0] = v;
      end
   endfunction

   assign access_w    = psel_i && penable_i && !pready_o;
   assign wr_w        = access_w && pwrite_i && pstrb_i[0];
   assign rd_w        = access_w && !pwrite_i;
   assign sel_valid_w = (select_reg != `DCIF_SEL_INVALID);
   assign cfg_wr_w    = wr_w && (paddr_i == `DCIF_ADDR_CONFIG) && sel_valid_w;

   // ==========================================
   // channel compare
   generate
      for (g = 0; g < NCH; g = g + 1)
      begin : g_ch
         dcif_chan_cmp #(.W(OW)) u_cmp
         (
            .offset_i (offset_i[g*OW +: OW]),
            .size_i   (size_i[g*OW +: OW]),
            .at_end_o (at_end_w[g]),
            .at_mid_o (at_mid_w[g])
         );
      end
   endgenerate

   // an offset sitting on a match sets once, not every cycle
   assign end_rise_w = at_end_w & ~end_d_reg;
   assign mid_rise_w = at_mid_w & ~mid_d_reg;

   // ==========================================
   // configuration store
   dcif_cfg_mem #(.DEPTH(NCH), .AW(3)) u_cfg
   (
      .clock_i       (clock_i),
      .rst_i         (rst_i),
      .wr_en_i       (cfg_wr_w),
      .wr_addr_i     (select_reg),
      .wr_data_i     (pwdata_i[7:0]),
      .rd_addr_i     (select_reg),
      .rd_data_o     (cfg_rd_w),
      .complete_en_o (complete_en_w),
      .midpoint_en_o (midpoint_en_w)
   );

   // ==========================================
   // flag next state
   always @*
   begin
      complete_next = complete_reg;
      midpoint_next = midpoint_reg;
      if (wr_w && paddr_i == `DCIF_ADDR_COMPLETE)
         complete_next = complete_reg & pwdata_i[NCH-1:0];
      if (wr_w && paddr_i == `DCIF_ADDR_MIDPOINT)
         midpoint_next = midpoint_reg & pwdata_i[NCH-1:0];
      complete_next = complete_next | end_rise_w;
      midpoint_next = midpoint_next | mid_rise_w;
   end

   always @*
   begin
      status_next = status_reg;
      if (rd_w && paddr_i == `DCIF_ADDR_STATUS)
         status_next = 2'b00;
      if (|(end_rise_w & complete_en_w))
         status_next[`DCIF_STS_COMPLETE] = 1'b1;
      if (|(mid_rise_w & midpoint_en_w))
         status_next[`DCIF_STS_MIDPOINT] = 1'b1;
   end

   // ==========================================
   // read mux
   always @*
   begin
      rdata_w = 32'h0000_0000;
      hit_w   = 1'b1;
      case (paddr_i)
         `DCIF_ADDR_COMPLETE: rdata_w = byte0(pad_flags(complete_reg));
         `DCIF_ADDR_MIDPOINT: rdata_w = byte0(pad_flags(midpoint_reg));
         `DCIF_ADDR_SELECT:   rdata_w = byte0({5'h00, select_reg});
         `DCIF_ADDR_CONFIG:   rdata_w = byte0(sel_valid_w ? cfg_rd_w : 8'h00);
         `DCIF_ADDR_WRAP:     rdata_w = byte0(pad_flags(wrap_reg));
         `DCIF_ADDR_STATUS:   rdata_w = byte0({6'h00, status_reg});
         `DCIF_ADDR_MASK:     rdata_w = byte0({6'h00, mask_reg});
         `DCIF_ADDR_BLOCKED:  rdata_w = byte0(pad_flags(complete_reg | midpoint_reg));
         default:
         begin
            rdata_w = 32'h0000_0000;
            hit_w   = 1'b0;
         end
      endcase
   end

   // ==========================================
   // registers
   always @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         complete_reg   <= {NCH{1'b0}};
         midpoint_reg   <= {NCH{1'b0}};
         select_reg     <= `DCIF_RST_SELECT;
         wrap_reg       <= {NCH{1'b0}};
         status_reg     <= 2'b00;
         mask_reg       <= 2'b00;
         end_d_reg      <= {NCH{1'b0}};
         mid_d_reg      <= {NCH{1'b0}};
         rd_cfg_reg     <= 1'b0;
         prdata_o       <= 32'h0000_0000;
         pready_o       <= 1'b0;
         pslverr_o      <= 1'b0;
         offset_clear_o <= {NCH{1'b0}};
         hold_o         <= {NCH{1'b0}};
         wrap_o         <= {NCH{1'b0}};
         dma_irq_o      <= 1'b0;
         block_irq_o    <= 1'b0;
      end
      else
      begin
         complete_reg <= complete_next;
         midpoint_reg <= midpoint_next;
         status_reg   <= status_next;
         end_d_reg    <= at_end_w;
         mid_d_reg    <= at_mid_w;
         if (wr_w && paddr_i == `DCIF_ADDR_SELECT)
            select_reg <= pwdata_i[2:0];
         if (wr_w && paddr_i == `DCIF_ADDR_WRAP)
            wrap_reg <= pwdata_i[NCH-1:0];
         if (wr_w && paddr_i == `DCIF_ADDR_MASK)
            mask_reg <= pwdata_i[1:0];
         // config reads wait one cycle for the registered store output
         rd_cfg_reg <= rd_w && (paddr_i == `DCIF_ADDR_CONFIG) && !rd_cfg_reg;
         if (access_w && !(rd_w && paddr_i == `DCIF_ADDR_CONFIG && !rd_cfg_reg))
         begin
            pready_o  <= 1'b1;
            pslverr_o <= !hit_w;
            prdata_o  <= pwrite_i ? 32'h0000_0000 : rdata_w;
         end
         else
         begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
         end
         offset_clear_o <= end_rise_w & wrap_reg;
         hold_o         <= (complete_next | midpoint_next) & ~wrap_reg;
         wrap_o         <= wrap_reg;
         dma_irq_o      <= |((complete_next & complete_en_w) |
                             (midpoint_next & midpoint_en_w));
         block_irq_o    <= |(status_next & mask_reg);
      end
   end
endmodule

// File: design/dcif_consts.vh
// constants for the dma channel interrupt flag block
`ifndef DCIF_CONSTS_VH
`define DCIF_CONSTS_VH
// ==========================================
// register byte addresses
`define DCIF_ADDR_COMPLETE   12'h0_0d0
`define DCIF_ADDR_MIDPOINT   12'h0_0d4
`define DCIF_ADDR_SELECT     12'h0_0d8
`define DCIF_ADDR_CONFIG     12'h0_0dc
`define DCIF_ADDR_WRAP       12'h0_0e0
`define DCIF_ADDR_STATUS     12'h0_0e4
`define DCIF_ADDR_MASK       12'h0_0e8
`define DCIF_ADDR_BLOCKED    12'h0_0ec
`define DCIF_MIDPOINT_PAGE   4'h2
// ==========================================
// field positions
`define DCIF_CFG_COMPLETE_EN 7
`define DCIF_CFG_MIDPOINT_EN 6
`define DCIF_FLAG_UNUSED     7
`define DCIF_SEL_INVALID     3'h7
`define DCIF_STS_COMPLETE    0
`define DCIF_STS_MIDPOINT    1
// ==========================================
// reset values
`define DCIF_RST_FLAGS       8'h00
`define DCIF_RST_CONFIG      8'h00
`define DCIF_RST_SELECT      3'h0
`endif

// File: design/dcif_cfg_mem.v
// per-channel configuration byte store with registered read
`timescale 1ns/10ps
`include "dcif_consts.vh"
module dcif_cfg_mem
#(
   parameter DEPTH = 7,
   parameter AW    = 3
)
(
   // clock and reset
   input  wire          clock_i,
   input  wire          rst_i,
   // write port
   input  wire          wr_en_i,
   input  wire [AW-1:0] wr_addr_i,
   input  wire [7:0]    wr_data_i,
   // read port
   input  wire [AW-1:0] rd_addr_i,
   output reg  [7:0]    rd_data_o,
   // all enables, bit 7 and bit 6 of every channel
   output reg  [DEPTH-1:0] complete_en_o,
   output reg  [DEPTH-1:0] midpoint_en_o
);
   reg [7:0] mem_reg [0:DEPTH-1];
   integer   i;
   // separate loop index keeps each variable in one process
   integer   j;

   always @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         for (i = 0; i < DEPTH; i = i + 1)
            mem_reg[i] <= `DCIF_RST_CONFIG;
         rd_data_o <= `DCIF_RST_CONFIG;
      end
      else
      begin
         if (wr_en_i && wr_addr_i < DEPTH)
            mem_reg[wr_addr_i] <= wr_data_i;
         rd_data_o <= (rd_addr_i < DEPTH) ? mem_reg[rd_addr_i] : 8'h00;
      end
   end

   always @*
   begin
      for (j = 0; j < DEPTH; j = j + 1)
      begin
         complete_en_o[j] = mem_reg[j][`DCIF_CFG_COMPLETE_EN];
         midpoint_en_o[j] = mem_reg[j][`DCIF_CFG_MIDPOINT_EN];
      end
   end
endmodule

// File: design/dcif_chan_cmp.v
// offset versus size comparison for one channel
`timescale 1ns/10ps
module dcif_chan_cmp
#(
   parameter W = 10
)
(
   // channel counters
   input  wire [W-1:0] offset_i,
   input  wire [W-1:0] size_i,
   // compare results
   output wire         at_end_o,
   output wire         at_mid_o
);
   wire [W-1:0] half_w;
   wire [W-1:0] mid_w;
   wire [W-1:0] last_w;

   assign half_w   = size_i >> 1;
   assign mid_w    = size_i[0] ? half_w + {{(W-1){1'b0}}, 1'b1} : half_w;
   assign last_w   = size_i - {{(W-1){1'b0}}, 1'b1};
   assign at_end_o = (size_i != {W{1'b0}}) && (offset_i == last_w);
   assign at_mid_o = (size_i != {W{1'b0}}) && (offset_i == mid_w);
endmodule

// File: dv/dcif_top_properties.sv
// assertion checker for the dma channel interrupt flag block
`timescale 1ns/10ps
`include "dcif_consts.vh"
module dcif_props
#(
   parameter NCH = 7,
   parameter OW  = 10
)
(
   // clock, reset and apb
   input wire           clock_i,
   input wire           rst_i,
   input wire           psel_i,
   input wire           penable_i,
   input wire           pwrite_i,
   input wire [11:0]    paddr_i,
   input wire [31:0]    prdata_o,
   input wire           pready_o,
   input wire           pslverr_o,
   // engine side and interrupts
   input wire [NCH-1:0] offset_clear_o,
   input wire [NCH-1:0] hold_o,
   input wire [NCH-1:0] wrap_o,
   input wire           dma_irq_o,
   input wire           block_irq_o
);
   // ==========================================
   // access history, a flag clear must follow a bus write, a status clear any bus access
   reg [2:0] wr_hist;
   reg [2:0] acc_hist;
   always @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wr_hist  <= 3'h0;
         acc_hist <= 3'h0;
      end
      else
      begin
         wr_hist  <= {wr_hist[1:0], psel_i & pwrite_i};
         acc_hist <= {acc_hist[1:0], psel_i};
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   flag_bit7_zero_a: assert property (
      pready_o && !pwrite_i && paddr_i[11:3] == 9'h01a |-> prdata_o[31:7] == 0)
      else $error("flag read shows bit 7 or above");
   mid_decode_a: assert property (psel_i && penable_i && !pready_o && paddr_i == `DCIF_ADDR_MIDPOINT
      |-> ##[1:2] pready_o && !pslverr_o) else $error("midpoint access not answered");
   err_ready_a: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   ready_pulse_a: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   clear_needs_wrap_a: assert property ((offset_clear_o & ~wrap_o) == 0)
      else $error("offset clear without wrap");
   clear_pulse_a: assert property ((offset_clear_o & $past(offset_clear_o)) == 0)
      else $error("clear not a pulse");
   hold_sticky_a: assert property (|($past(hold_o) & ~hold_o) |-> |wr_hist)
      else $error("hold dropped alone");
   irq_sticky_a: assert property ($fell(dma_irq_o) |-> |wr_hist)
      else $error("irq dropped alone");
   block_fall_a: assert property ($fell(block_irq_o) |-> |acc_hist)
      else $error("status irq dropped alone");
   cover property (|hold_o);
   cover property (|offset_clear_o);
   cover property (dma_irq_o && block_irq_o);
endmodule
bind dcif_top dcif_props #(.NCH(NCH), .OW(OW)) dcif_props_i (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .offset_clear_o(offset_clear_o), .hold_o(hold_o), .wrap_o(wrap_o),
   .dma_irq_o(dma_irq_o), .block_irq_o(block_irq_o));

// File: dv/dcif_top_tb_top.sv
// self-checking testbench for the dma channel interrupt flag block
`timescale 1ns/10ps
`include "dcif_consts.vh"
module dcif_top_tb_top;
   // ==========================================
   // ports and bench state
   localparam NCH = 7;
   localparam OW  = 10;
   localparam [11:0] A_CMP = `DCIF_ADDR_COMPLETE;
   localparam [11:0] A_MID = `DCIF_ADDR_MIDPOINT;
   localparam [11:0] A_SEL = `DCIF_ADDR_SELECT;
   localparam [11:0] A_CFG = `DCIF_ADDR_CONFIG;
   logic              clock_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, dma_irq_o, block_irq_o, er;
   logic [11:0]       paddr_i;
   logic [31:0]       pwdata_i, prdata_o, rd;
   logic [NCH*OW-1:0] off, sz;
   logic [NCH-1:0]    offset_clear_o, hold_o, wrap_o;
   logic [7:0]        cfg;
   logic [3:0]        strb;
   int                n_mismatch = 0, n_checks = 0, ch, size, k;
   dcif_top #(.NCH(NCH), .OW(OW)) dcif_top_i (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(strb),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .offset_i(off), .size_i(sz),
      .byte_done_i(7'h00), .offset_clear_o(offset_clear_o), .hold_o(hold_o), .wrap_o(wrap_o),
      .dma_irq_o(dma_irq_o), .block_irq_o(block_irq_o));
   initial
   begin
      clock_i = 0;
      forever #12.5 clock_i = ~clock_i;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // master holds the request until pready is seen high at an edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock_i);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1;
      k = 0;
      // no local limit: a hung slave is caught by the watchdog
      do
      begin
         @(posedge clock_i);
         k++;
      end while (pready_o !== 1'b1);
      chk(k, (a == A_CFG && !w) ? 3 : 2);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask
   task rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb(0, a, 0);
      chk(rd, e);
   endtask
   function int mid_of(input int s);
      return (s % 2) ? s / 2 + 1 : s / 2;
   endfunction
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      #1000000;
      n_mismatch++;
      close_out;
   end
   // ==========================================
   // main sequence
   initial
   begin
      rst_i = 1;
      strb = 4'hf;
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, off, sz} = 0;
      k = $urandom(47);
      repeat (6) @(posedge clock_i);
      rst_i <= 0;
      @(posedge clock_i);
      chk({hold_o, wrap_o, offset_clear_o, dma_irq_o, block_irq_o}, 0);
      rd_chk(A_CMP, 0);
      rd_chk(A_MID, 0);
      apb(0, 12'h0_0f0, 0);
      chk(er, 1);
      // a write without byte lane 0 must leave the register alone
      strb <= 4'he;
      apb(1, A_SEL, 5);
      strb <= 4'hf;
      rd_chk(A_SEL, 0);
      apb(1, A_SEL, 7);
      apb(1, A_CFG, 8'hc0);
      rd_chk(A_CFG, 0);
      apb(1, `DCIF_ADDR_MASK, 3);
      rd_chk(`DCIF_ADDR_MASK, 3);
      for (ch = 0; ch < NCH; ch++)
      begin
         cfg = 8'($urandom);
         size = (ch == 0) ? 5 : (ch == 1) ? 1023 : 4 + $urandom % 1000;
         apb(1, A_SEL, ch);
         rd_chk(A_SEL, ch);
         apb(1, A_CFG, cfg);
         rd_chk(A_CFG, cfg);
         sz[ch*OW +: OW] <= size;
         @(posedge clock_i);
         off[ch*OW +: OW] <= mid_of(size);
         repeat (3) @(posedge clock_i);
         rd_chk(A_MID, 1 << ch);
         chk(dma_irq_o, cfg[6]);
         off[ch*OW +: OW] <= size - 1;
         repeat (3) @(posedge clock_i);
         rd_chk(A_CMP, 1 << ch);
         chk(hold_o, 1 << ch);
         rd_chk(`DCIF_ADDR_BLOCKED, 1 << ch);
         chk(dma_irq_o, cfg[6] | cfg[7]);
         chk(block_irq_o, cfg[6] | cfg[7]);
         rd_chk(`DCIF_ADDR_STATUS, {cfg[6], cfg[7]});
         repeat (2) @(posedge clock_i);
         chk(block_irq_o, 0);
         apb(1, A_CMP, 8'hff);
         rd_chk(A_CMP, 1 << ch);
         apb(1, A_MID, 8'h80);
         rd_chk(A_MID, 0);
         apb(1, A_CMP, 0);
         rd_chk(A_CMP, 0);
         repeat (2) @(posedge clock_i);
         chk({hold_o, dma_irq_o}, 0);
         off <= 0;
         sz <= 0;
      end
      apb(1, A_SEL, 0);
      apb(1, `DCIF_ADDR_WRAP, 1);
      @(posedge clock_i);
      chk(wrap_o, 1);
      sz[OW-1:0] <= 6;
      @(posedge clock_i);
      off[OW-1:0] <= 5;
      // the clear pulse is seen two edges after the offset reaches size minus one
      k = 0;
      while (offset_clear_o[0] !== 1'b1)
      begin
         @(posedge clock_i);
         k++;
      end
      chk(k, 2);
      off[OW-1:0] <= 0;
      repeat (3) @(posedge clock_i);
      chk(hold_o, 0);
      rd_chk(A_CMP, 1);
      // a system reset in mid-run must drop the flag still standing
      rst_i <= 1;
      repeat (2) @(posedge clock_i);
      rst_i <= 0;
      @(posedge clock_i);
      chk({hold_o, wrap_o, offset_clear_o, dma_irq_o, block_irq_o}, 0);
      rd_chk(A_CMP, 0);
      close_out;
   end
endmodule
